/* File: testbench/iuvfr_ctrl_tb.sv */
// self-checking bench for the under-voltage responder
`timescale 1ns/1ps
module iuvfr_ctrl_tb;
	import iuvfr_pkg::*;
	logic clk = 0, resetn = 0, uv = 0, on = 1, sclr = 0, rreq = 0;
	logic tick = 1;
	iuvfr_cmd_t cmd;
	logic [7:0] rd, d;
	logic rv, ack, oe, fl;
	logic [2:0] att;
	iuvfr_state_t st;
	int failures = 0, n_compared = 0, cyc = 0, n, t0;
	logic [7:0] q[$];
	logic [2:0] rt[4] = '{3'h0, 3'h1, 3'h2, 3'h6};
	logic [2:0] ex[3] = '{3'h0, 3'h2, 3'h7};
	initial forever #2.5 clk = ~clk;
	iuvfr_host i_host (.clk(clk), .cmd(cmd));
	// unit tick mostly high: one delay unit per clock keeps waits short
	iuvfr_ctrl i_dut (.clk(clk), .resetn(resetn), .cmd(cmd),
		.uv_fault(uv), .unit_tick(tick), .output_on_cmd(on),
		.status_clear(sclr), .reset_req(rreq), .rd_data_ff(rd),
		.rd_valid_ff(rv), .cmd_ack_ff(ack), .out_enable_ff(oe),
		.fault_latched_ff(fl), .attempts_ff(att), .state_ff(st));
	task automatic check(input string nm, input logic [7:0] s, e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic results();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cy(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// bounded wait for a state; cycles taken come back in w
	task automatic till(input iuvfr_state_t s, output int w);
		w = 0;
		while (st !== s && w < 600) begin
			cy(1);
			w++;
		end
		check("till", st, s);
	endtask
	task automatic wr(input logic [7:0] v);
		i_host.xfer(1'h1, CMD_UV_ACTION, v);
		check("wr_ack", ack, 8'h01);
	endtask
	task automatic rd_exp(input logic [7:0] e);
		q.push_back(e);
		i_host.xfer(1'h0, CMD_UV_ACTION, 8'h00);
	endtask
	task automatic clr();
		i_host.xfer(1'h1, CMD_CLEAR_FAULTS, 8'h00);
	endtask
	// read monitor: each fresh byte is matched to the oldest note
	always @(negedge clk) if (rv === 1'h1) begin
		check("rd_data", rd, q.pop_front());
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			results();
		end
	end
	initial begin
		void'($urandom(9));
		cy(16);
		resetn = 1;
		cy(2);
		rd_exp(ACTION_RESET);
		d = $urandom;
		wr(d);
		rd_exp(d);
		i_host.xfer(1'h0, 8'h5B, 8'h00);
		check("unmapped", ack, 8'h00);
		wr({RESP_IGNORE, 6'h3F});
		uv = 1;
		cy(8);
		check("ignore", {oe, fl}, 8'h02);
		uv = 0;
		// every clear path out of the latched state
		wr({RESP_LATCH, 6'h00});
		for (int k = 0; k < 4; k++) begin
			uv = 1;
			cy(2);
			uv = 0;
			cy(2);
			check("latch", {st, oe, fl}, {ST_LATCH, 2'h1});
			sclr = (k == 0);
			rreq = (k == 1);
			on = (k != 2);
			if (k == 3) clr();
			else cy(1);
			sclr = 0;
			rreq = 0;
			on = 1;
			till(ST_RUN, n);
			check("cleared", {oe, fl}, 8'h02);
		end
		foreach (rt[i]) begin
			wr({RESP_RETRY, rt[i], 3'h0});
			uv = 1;
			cy(2);
			check("off_now", oe, 8'h00);
			till(ST_LATCH, n);
			check("tries", att, rt[i]);
			uv = 0;
			clr();
			till(ST_RUN, n);
			check("cnt_zero", att, 8'h00);
		end
		wr({RESP_RETRY, RETRY_FOREVER, 3'h0});
		uv = 1;
		cy(400);
		check("forever", st, ST_WAIT);
		check("forever_cnt", att, 8'h00);
		on = 0;
		cy(2);
		check("cmd_off", st, ST_OFF);
		on = 1;
		uv = 0;
		till(ST_RUN, n);
		// without unit ticks the retry span must not run out
		tick = 0;
		wr({RESP_RETRY, 3'h1, 3'h0});
		uv = 1;
		cy(20);
		check("no_tick", st, ST_WAIT);
		tick = 1;
		till(ST_LATCH, n);
		uv = 0;
		clr();
		till(ST_RUN, n);
		// spacing grows as 2^n units
		foreach (ex[i]) begin
			wr({RESP_RETRY, 3'h1, ex[i]});
			uv = 1;
			till(ST_WAIT, n);
			uv = 0;
			till(ST_RUN, n);
			if (i == 0) t0 = n;
			else check("span", n - t0, (8'h01 << ex[i]) - 8'h01);
		end
		wr({RESP_GRACE, RETRY_NONE, 3'h7});
		uv = 1;
		cy(2);
		check("grace", {st, oe, fl}, {ST_GRACE, 2'h3});
		uv = 0;
		cy(2);
		check("grace_end", st, ST_RUN);
		uv = 1;
		till(ST_LATCH, n);
		check("grace_len", n > 120, 8'h01);
		check("grace_off", oe, 8'h00);
		// reset in mid-run restores the byte and drops the flag
		uv = 0;
		resetn = 0;
		cy(2);
		resetn = 1;
		cy(1);
		check("rst_run", {st, oe, fl}, {ST_RUN, 2'h2});
		rd_exp(ACTION_RESET);
		cy(2);
		check("reads_left", q.size(), 8'h00);
		results();
	end
endmodule

/* File: testbench/iuvfr_host.sv */
// host model issuing byte transactions to the responder
`timescale 1ns/1ps
module iuvfr_host
	import iuvfr_pkg::*;
(
	input wire logic clk,
	output iuvfr_cmd_t cmd
);
	initial cmd = '0;
	// one-cycle request; fields inverted when idle so no stale byte lingers
	task automatic xfer(input logic w, input logic [7:0] c,
		input logic [7:0] d);
		@(posedge clk);
		#1 cmd = '{1'h1, w, c, d};
		@(posedge clk);
		#1 cmd = '{1'h0, ~w, ~c, ~d};
	endtask
endmodule

/* File: verilog/iuvfr_ctrl.sv */
// fault responder for the input under-voltage fault with its action byte
// Behaviour
// - response 00 ignores fault, output keeps running
// - response 01 runs for delay, then retries
// - response 10 disables at once, then retries
// - response 11 latches off until cleared
// - status clear, clear command or reset clear fault
// - off-then-on command also clears latched fault
// - retry 000 latches output off, no restart
// - retry 1..5 attempts, then latch off
// - attempts spaced by 2^delay field units
// - action byte read and written at 0x5A
// - retry 6 attempts, 7 retries without limit
// - delay code n means 2^n units
`timescale 1ns/1ps
module iuvfr_ctrl
	import iuvfr_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire iuvfr_cmd_t cmd,
	input wire logic uv_fault,
	input wire logic unit_tick,
	input wire logic output_on_cmd,
	input wire logic status_clear,
	input wire logic reset_req,
	output logic [7:0] rd_data_ff,
	output logic rd_valid_ff,
	output logic cmd_ack_ff,
	output logic out_enable_ff,
	output logic fault_latched_ff,
	output logic [2:0] attempts_ff,
	output iuvfr_state_t state_ff
);
	logic [7:0] action_ff, nxt_action;
	logic [7:0] nxt_rd_data;
	logic nxt_rd_valid, nxt_ack;
	logic on_prev_ff;
	iuvfr_state_t nxt_state;
	logic nxt_out_en, nxt_flag;
	logic [2:0] nxt_attempts;
	logic [1:0] resp;
	logic [2:0] retry;
	logic [2:0] dly;
	logic hit_action, hit_clear, on_rise, clr, flag_set;
	logic tmr_start, tmr_stop, tmr_done;
	logic [3:0] tries_next;
	logic success;

	assign resp = action_ff[RESP_HI:RESP_LO];
	assign retry = action_ff[RETRY_HI:RETRY_LO];
	assign dly = action_ff[DELAY_HI:DELAY_LO];

	// command decode; other codes are left to other blocks, no ack
	assign hit_action = cmd.valid && cmd.code == CMD_UV_ACTION;
	assign hit_clear = cmd.valid && cmd.write &&
		cmd.code == CMD_CLEAR_FAULTS;
	// off-then-on seen as a rising edge of the resolved on command
	assign on_rise = output_on_cmd && !on_prev_ff;
	assign clr = status_clear || hit_clear || reset_req || on_rise;
	assign tries_next = {1'b0, attempts_ff} + 4'h1;

	// register file: one byte, read data valid one cycle after request
	always_comb begin
		nxt_action = action_ff;
		nxt_rd_data = rd_data_ff;
		nxt_rd_valid = 1'b0;
		nxt_ack = hit_action || hit_clear;
		if (hit_action && cmd.write) begin
			nxt_action = cmd.data;
		end else if (hit_action) begin
			nxt_rd_data = action_ff;
			nxt_rd_valid = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			action_ff <= ACTION_RESET;
			rd_data_ff <= 8'h00;
			rd_valid_ff <= 1'b0;
			cmd_ack_ff <= 1'b0;
		end else begin
			action_ff <= nxt_action;
			rd_data_ff <= nxt_rd_data;
			rd_valid_ff <= nxt_rd_valid;
			cmd_ack_ff <= nxt_ack;
		end
	end

	// response sequencer; commanded off beats everything else
	always_comb begin
		nxt_state = state_ff;
		nxt_attempts = attempts_ff;
		flag_set = 1'b0;
		tmr_start = 1'b0;
		success = 1'b0;
		if (!output_on_cmd) begin
			nxt_state = ST_OFF;
			nxt_attempts = 3'h0;
		end else begin
			case (state_ff)
				ST_OFF: begin
					nxt_state = ST_RUN;
				end
				ST_RUN: begin
					if (uv_fault) begin
						case (resp)
							RESP_IGNORE: nxt_state = ST_RUN;
							RESP_GRACE: begin
								nxt_state = ST_GRACE;
								tmr_start = 1'b1;
								flag_set = 1'b1;
							end
							RESP_RETRY: begin
								flag_set = 1'b1;
								if (retry == RETRY_NONE) begin
									nxt_state = ST_LATCH;
								end else begin
									nxt_state = ST_WAIT;
									tmr_start = 1'b1;
								end
							end
							default: begin
								nxt_state = ST_LATCH;
								flag_set = 1'b1;
							end
						endcase
					end
				end
				ST_GRACE: begin
					if (clr || !uv_fault) begin
						nxt_state = ST_RUN;
					end else if (tmr_done) begin
						// still faulty after the grace span
						if (retry == RETRY_NONE) begin
							nxt_state = ST_LATCH;
						end else begin
							nxt_state = ST_WAIT;
							tmr_start = 1'b1;
						end
					end
				end
				ST_WAIT: begin
					if (clr) begin
						nxt_state = ST_RUN;
						nxt_attempts = 3'h0;
					end else if (tmr_done) begin
						// an attempt succeeds if the input is back in range
						if (!uv_fault) begin
							nxt_state = ST_RUN;
							success = 1'b1;
							nxt_attempts = 3'h0;
						end else if (retry != RETRY_FOREVER &&
							tries_next >= {1'b0, retry}) begin
							nxt_state = ST_LATCH;
							// count kept while latched, for the host
							nxt_attempts = tries_next[2:0];
						end else begin
							tmr_start = 1'b1;
							if (retry != RETRY_FOREVER) begin
								nxt_attempts = tries_next[2:0];
							end
						end
					end
				end
				ST_LATCH: begin
					if (clr) begin
						nxt_state = ST_RUN;
						nxt_attempts = 3'h0;
					end
				end
				default: nxt_state = ST_OFF;
			endcase
		end
		nxt_out_en = nxt_state == ST_RUN || nxt_state == ST_GRACE;
		// a new fault in the clearing cycle stays latched
		nxt_flag = flag_set || (fault_latched_ff && !clr);
		tmr_stop = nxt_state != ST_GRACE && nxt_state != ST_WAIT;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_ff <= ST_OFF;
			attempts_ff <= 3'h0;
			out_enable_ff <= 1'b0;
			fault_latched_ff <= 1'b0;
			on_prev_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			attempts_ff <= nxt_attempts;
			out_enable_ff <= nxt_out_en;
			fault_latched_ff <= nxt_flag;
			on_prev_ff <= output_on_cmd;
		end
	end

	// one timer serves both the grace span and the retry spacing
	iuvfr_delay_timer u_timer (
		.clk(clk),
		.resetn(resetn),
		.start(tmr_start),
		.stop(tmr_stop),
		.unit_tick(unit_tick),
		.exponent(dly),
		.done(tmr_done)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_ignore_keeps_on: assert property (
		state_ff == ST_RUN && resp == RESP_IGNORE && uv_fault &&
		output_on_cmd |=> state_ff == ST_RUN && out_enable_ff)
		else $error("ignore mode left run state");
	chk_grace_output_on: assert property (
		state_ff == ST_GRACE |-> out_enable_ff && fault_latched_ff)
		else $error("output off during grace span");
	chk_disable_at_once: assert property (
		state_ff == ST_RUN && uv_fault && resp == RESP_RETRY &&
		output_on_cmd |=> !out_enable_ff)
		else $error("retry mode did not disable output");
	chk_latch_holds_off: assert property (
		state_ff == ST_LATCH && !clr && output_on_cmd
		|=> state_ff == ST_LATCH && !out_enable_ff)
		else $error("latched state left without clear");
	chk_clear_drops_flag: assert property (
		clr && !flag_set |=> !fault_latched_ff)
		else $error("fault flag survived a clear");
	chk_off_on_restarts: assert property (
		on_rise && state_ff == ST_OFF
		|=> state_ff == ST_RUN && out_enable_ff && !fault_latched_ff)
		else $error("off-then-on did not restart output");
	chk_no_retry_latch: assert property (
		state_ff == ST_RUN && uv_fault && resp == RESP_RETRY &&
		retry == RETRY_NONE && output_on_cmd |=> state_ff == ST_LATCH)
		else $error("retry 000 did not latch off");
	chk_attempt_limit: assert property (
		state_ff == ST_WAIT && tmr_done && uv_fault && !clr &&
		output_on_cmd && retry != RETRY_FOREVER &&
		tries_next >= {1'b0, retry} |=> state_ff == ST_LATCH)
		else $error("attempt limit not enforced");
	chk_endless_retry: assert property (
		state_ff == ST_WAIT && tmr_done && uv_fault && !clr &&
		output_on_cmd && retry == RETRY_FOREVER |=> state_ff == ST_WAIT)
		else $error("continuous retry gave up");
	chk_success_resets: assert property (
		success && output_on_cmd |=> attempts_ff == 3'h0 && out_enable_ff)
		else $error("successful restart kept attempt count");
	chk_byte_write: assert property (
		hit_action && cmd.write |=> action_ff == $past(cmd.data) &&
		cmd_ack_ff)
		else $error("action byte not stored");
	chk_byte_read: assert property (
		hit_action && !cmd.write |=> rd_valid_ff &&
		rd_data_ff == $past(action_ff))
		else $error("action byte read mismatch");

	cov_grace_to_wait: cover property (
		state_ff == ST_GRACE ##1 state_ff == ST_WAIT);
	cov_latch_entry: cover property (
		state_ff == ST_WAIT ##1 state_ff == ST_LATCH);
	cov_restart_ok: cover property (success);
	cov_clear_latch: cover property (
		state_ff == ST_LATCH ##1 state_ff == ST_RUN);
endmodule

/* File: verilog/iuvfr_delay_timer.sv */
// power-of-two delay timer counting external time-unit ticks
`timescale 1ns/1ps
module iuvfr_delay_timer
	import iuvfr_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic stop,
	input wire logic unit_tick,
	input wire logic [2:0] exponent,
	output logic done
);
	logic [TMR_W-1:0] cnt_ff, nxt_cnt;
	logic busy_ff, nxt_busy;
	logic done_ff, nxt_done;
	logic [TMR_W-1:0] target;

	// n maps to 2^n units, so 0 is one unit and 7 is 128
	assign target = TMR_ONE << exponent;
	assign done = done_ff;

	// next count; start wins over stop so a re-arm is never lost
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		if (start) begin
			nxt_cnt = '0;
			nxt_busy = 1'b1;
		end else if (stop) begin
			nxt_busy = 1'b0;
		end else if (busy_ff && unit_tick) begin
			if (cnt_ff == target - TMR_ONE) begin
				nxt_done = 1'b1;
				nxt_busy = 1'b0;
			end
			nxt_cnt = cnt_ff + TMR_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_ff <= '0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_done_after_span: assert property (
		done_ff |-> $past(unit_tick) && $past(cnt_ff) == $past(target) - TMR_ONE)
		else $error("timer done before full span");
endmodule

/* File: verilog/iuvfr_pkg.sv */
// constants, types and command codes for the input under-voltage responder
package iuvfr_pkg;
	// command codes on the management bus
	localparam logic [7:0] CMD_UV_ACTION = 8'h5A;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	// reset value of the action byte: latch off, no retry, 1 unit
	localparam logic [7:0] ACTION_RESET = 8'hC0;
	// field positions inside the action byte
	localparam int RESP_HI = 7;
	localparam int RESP_LO = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int DELAY_HI = 2;
	localparam int DELAY_LO = 0;
	// response field encodings
	localparam logic [1:0] RESP_IGNORE = 2'h0;
	localparam logic [1:0] RESP_GRACE = 2'h1;
	localparam logic [1:0] RESP_RETRY = 2'h2;
	localparam logic [1:0] RESP_LATCH = 2'h3;
	// retry field encodings
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	// timer width: 2^7 = 128 units is the longest delay
	localparam int TMR_W = 8;
	localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;

	// one decoded byte transaction from the bus transaction layer
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [7:0] data;
	} iuvfr_cmd_t;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_RUN = 3'b001,
		ST_GRACE = 3'b010,
		ST_WAIT = 3'b011,
		ST_LATCH = 3'b100
	} iuvfr_state_t;
endpackage
